// ===== core/cbr_pkg.sv
// constants and types shared by the clock buffer serial control block
// ----------------------------------------
// ----------------------------------------
package cbr_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h69;
  localparam logic [7:0] OFS_ENABLES = 8'h00;
  localparam logic [7:0] OFS_IDENT = 8'h06;
  localparam logic [7:0] OFS_LAST = 8'h06;
  localparam int NUM_REGS = 7;
  localparam logic [3:0] ENABLE_RESET = 4'hF;
  // arbitrary neutral identification values
  localparam logic [3:0] REV_RESET = 4'h3;
  localparam logic [3:0] MAKER_RESET = 4'hA;
  localparam logic [7:0] RSVD_RESET = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_WRITE = 3'b011,
    ST_READ = 3'b100,
    ST_RACK = 3'b101,
    ST_SKIP = 3'b110
  } cbr_state_t;

  // which byte of a write we are in
  typedef enum logic [1:0] {
    WB_OFFSET = 2'b00,
    WB_COUNT = 2'b01,
    WB_DATA = 2'b10
  } cbr_wbyte_t;
endpackage

// ===== core/cbr_sync.sv
// two-flop synchroniser with edge detection for the serial pins
`timescale 1ns/1ps
`default_nettype none
module cbr_sync
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);
  logic [2:0] shift;

  // the first stage feeds only the second stage
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      shift <= 3'h7;
    else
      shift <= {shift[1:0], pinIn};
  end

  assign level = shift[1];
  assign rise = shift[1] & ~shift[2];
  assign fall = ~shift[1] & shift[2];
endmodule
`default_nettype wire

// ===== core/cbr_serial_regs.sv
// serial target and register file of the clock buffer
`timescale 1ns/1ps
`default_nettype none
module cbr_serial_regs
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [3:0] pin_enable_first_output,
  output logic [7:0] outputEnable
);
  import cbr_pkg::*;

  typedef struct packed {
    cbr_state_t state;
    cbr_wbyte_t wbyte;
    logic [2:0] bitCnt;
    logic gotBit;
    logic [7:0] shift;
    logic [7:0] pointer;
    logic isRead;
    logic countSent;
    logic ackDrive;
    logic [7:0] txByte;
    logic [NUM_REGS-1:0][7:0] regs;
    logic [3:0] pinEn1;
    logic [3:0] pinEn2;
  } cbr_core_t;

  cbr_core_t cur;
  cbr_core_t nxt;
  logic scl;
  logic sclRise;
  logic sclFall;
  logic sda;
  logic sdaRise;
  logic sdaFall;
  logic startCond;
  logic stopCond;

  cbr_sync sclSync
  (
    .core_clk(core_clk),
    .rst(rst),
    .pinIn(sclIn),
    .level(scl),
    .rise(sclRise),
    .fall(sclFall)
  );

  cbr_sync sdaSync
  (
    .core_clk(core_clk),
    .rst(rst),
    .pinIn(sdaIn),
    .level(sda),
    .rise(sdaRise),
    .fall(sdaFall)
  );

  assign startCond = scl & sdaFall;
  assign stopCond = scl & sdaRise;

  function automatic logic [7:0] readReg(input cbr_core_t c,
                                         input logic [7:0] ofs);
    if (ofs <= OFS_LAST)
      readReg = c.regs[ofs[2:0]];
    else
      readReg = 8'h00;
  endfunction

  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  always_comb
  begin
    nxt = cur;
    nxt.pinEn1 = pin_enable_first_output;
    nxt.pinEn2 = cur.pinEn1;
    if (startCond)
    begin
      // start or repeated start; pointer is kept for the read phase
      nxt.state = ST_ADDR;
      nxt.bitCnt = 3'h0;
      nxt.gotBit = 1'b0;
      nxt.ackDrive = 1'b0;
    end
    else if (stopCond)
    begin
      nxt.state = ST_IDLE;
      nxt.ackDrive = 1'b0;
    end
    else
    begin
      case (cur.state)
        ST_ADDR, ST_WRITE:
        begin
          // the fall that closes a start condition carries no bit
          if (sclRise)
          begin
            nxt.shift = {cur.shift[6:0], sda};
            nxt.gotBit = 1'b1;
          end
          if (sclFall && cur.gotBit)
          begin
            nxt.gotBit = 1'b0;
            nxt.bitCnt = cur.bitCnt + 3'h1;
            if (cur.bitCnt == BIT_LAST)
            begin
              if (cur.state == ST_ADDR)
              begin
                if (cur.shift[7:1] == DEV_ADDR)
                begin
                  nxt.state = ST_ACK;
                  nxt.ackDrive = 1'b1;
                  nxt.isRead = cur.shift[0];
                  nxt.wbyte = WB_OFFSET;
                  nxt.countSent = 1'b0;
                end
                else
                  nxt.state = ST_SKIP;
              end
              else
              begin
                nxt.state = ST_ACK;
                nxt.ackDrive = 1'b1;
                case (cur.wbyte)
                  WB_OFFSET:
                  begin
                    nxt.pointer = cur.shift;
                    nxt.wbyte = WB_COUNT;
                  end
                  WB_COUNT:
                    nxt.wbyte = WB_DATA; // count byte is acked but not stored or used
                  default:
                  begin
                    if (cur.pointer <= OFS_LAST)
                      nxt.regs[cur.pointer[2:0]] = cur.shift;
                    nxt.pointer = cur.pointer + 8'h01;
                  end
                endcase
              end
            end
          end
        end
        ST_ACK:
        begin
          if (sclFall)
          begin
            nxt.ackDrive = 1'b0;
            nxt.bitCnt = 3'h0;
            if (cur.isRead)
            begin
              nxt.state = ST_READ;
              // byte count first, then data from the pointer
              nxt.txByte = NUM_REGS[7:0];
              nxt.countSent = 1'b1;
            end
            else
              nxt.state = ST_WRITE;
          end
        end
        ST_READ:
        begin
          if (sclFall)
          begin
            nxt.bitCnt = cur.bitCnt + 3'h1;
            nxt.txByte = {cur.txByte[6:0], 1'b0};
            if (cur.bitCnt == BIT_LAST)
              nxt.state = ST_RACK;
          end
        end
        ST_RACK:
        begin
          if (sclRise && sda)
            nxt.state = ST_SKIP; // host nack ends the read
          else if (sclFall)
          begin
            nxt.state = ST_READ;
            nxt.bitCnt = 3'h0;
            nxt.txByte = readReg(cur, cur.pointer);
            nxt.pointer = cur.pointer + 8'h01;
          end
        end
        default:
          nxt.state = cur.state;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cur <= '0;
      cur.state <= ST_IDLE;
      cur.pinEn1 <= ENABLE_RESET;
      cur.pinEn2 <= ENABLE_RESET;
      for (int i = 0; i < NUM_REGS; i++)
        cur.regs[i] <= RSVD_RESET;
      cur.regs[OFS_ENABLES[2:0]] <= {RSVD_RESET[7:4], ENABLE_RESET};
      cur.regs[OFS_IDENT[2:0]] <= {REV_RESET, MAKER_RESET};
    end
    else
      cur <= nxt;
  end

  // open-drain: only ever pull low
  assign sdaOut = 1'b0;
  assign sdaOe = cur.ackDrive | (cur.state == ST_READ && !cur.txByte[7]);

  // ----------------------------------------
  // output enables
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gen_oe
      assign outputEnable[g] = cur.pinEn2[g];
      assign outputEnable[4 + g] = cur.regs[OFS_ENABLES[2:0]][3 - g];
    end
  endgenerate

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence addrByteDone;
    cur.state == ST_ADDR && sclFall && cur.gotBit && cur.bitCnt == BIT_LAST;
  endsequence

  sequence writeByteDone;
    cur.state == ST_WRITE && sclFall && cur.gotBit && cur.bitCnt == BIT_LAST;
  endsequence

  ack_on_match_a: assert property (@(posedge core_clk)
    disable iff (rst) addrByteDone ##0 (cur.shift[7:1] == DEV_ADDR
      && !startCond && !stopCond) |=> sdaOe)
    else $error("no ack for own address");

  no_foreign_ack_a: assert property (@(posedge core_clk)
    disable iff (rst) addrByteDone ##0 (cur.shift[7:1] != DEV_ADDR
      && !startCond && !stopCond) |=> !sdaOe)
    else $error("ack for foreign address");

  steady_while_high_a: assert property (@(posedge core_clk)
    disable iff (rst) scl && $past(scl) |-> $stable(sdaOe))
    else $error("sda moved while scl high");

  offset_load_a: assert property (@(posedge core_clk)
    disable iff (rst) writeByteDone ##0 (cur.wbyte == WB_OFFSET
      && !startCond && !stopCond) |=> cur.pointer == $past(cur.shift))
    else $error("pointer not loaded");

  upper_enable_a: assert property (@(posedge core_clk)
    disable iff (rst) writeByteDone ##0 (cur.wbyte == WB_DATA
      && cur.pointer == OFS_ENABLES && !startCond && !stopCond)
      |=> outputEnable[7:4] == {$past(cur.shift[0]), $past(cur.shift[1]),
      $past(cur.shift[2]), $past(cur.shift[3])})
    else $error("upper enables wrong");

  pin_enable_a: assert property (@(posedge core_clk)
    disable iff (rst)
    ##2 outputEnable[3:0] == $past(pin_enable_first_output, 2))
    else $error("pin enables wrong");

  ident_stable_a: assert property (@(posedge core_clk)
    disable iff (rst) !(cur.state == ST_WRITE && sclFall)
      |=> $stable(cur.regs[6]))
    else $error("ident changed without write");

  high_drop_a: assert property (@(posedge core_clk)
    disable iff (rst) cur.pointer > OFS_LAST |=> cur.regs == $past(cur.regs))
    else $error("write beyond map stored");

  data_ack_a: assert property (@(posedge core_clk)
    disable iff (rst) writeByteDone ##0 (!startCond && !stopCond)
      |=> sdaOe ##0 cur.state == ST_ACK)
    else $error("data byte not acked");

  count_first_a: assert property (@(posedge core_clk)
    disable iff (rst) cur.state == ST_ACK && cur.isRead && sclFall
      && !startCond && !stopCond |=> cur.txByte == NUM_REGS[7:0])
    else $error("count not sent first");

  reserved_inert_a: assert property (@(posedge core_clk)
    disable iff (rst) $changed(cur.regs[1]) |-> $stable(outputEnable))
    else $error("reserved byte affected outputs");
endmodule
`default_nettype wire

// ===== tb/cbr_host.sv
// I2C host model that drives the serial pins of the clock buffer
`timescale 1ns/1ps
`default_nettype none
module cbr_host
(
  input wire logic core_clk,
  input wire logic sdaOe,
  input wire logic sdaOut,
  output logic scl,
  output logic sda
);
  // ----
  // bus wires
  // ----
  logic drv;
  // pull-up on the wire: low while either party pulls it; a high drive
  // from the device would fight the bus, so it shows up as unknown
  assign sda = sdaOe ? (sdaOut ? 1'bx : 1'b0) : drv;
  initial
  begin
    scl = 1'b1;
    drv = 1'b1;
  end
  // half of the 80 ns link period; the clock stands still between frames
  task automatic h();
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic start();
    drv = 1'b1;
    h();
    scl = 1'b1;
    h();
    drv = 1'b0;
    h();
    scl = 1'b0;
  endtask
  task automatic stop();
    drv = 1'b0;
    h();
    scl = 1'b1;
    h();
    drv = 1'b1;
    h();
  endtask
  task automatic bx(input logic b, output logic s);
    drv = b;
    h();
    scl = 1'b1;
    h();
    s = sda;
    scl = 1'b0;
  endtask
  // msb first, then the acknowledge slot driven with ak
  task automatic xb(input logic [7:0] b, input logic ak,
                    output logic [7:0] r, output logic s);
    for (int i = 7; i >= 0; i--)
      bx(b[i], r[i]);
    bx(ak, s);
  endtask
endmodule
`default_nettype wire

// ===== tb/cbr_serial_regs_tb.sv
// self-checking bench of the clock buffer serial control block
`timescale 1ns/1ps
`default_nettype none
module cbr_serial_regs_tb;
  import cbr_pkg::*;
  logic core_clk;
  logic rst;
  logic [3:0] pins;
  logic sdaOe;
  logic sdaOut;
  logic scl;
  logic sda;
  logic [7:0] outputEnable;
  logic [7:0] r;
  logic s;
  int miscompares;
  int totalChecks;
  int cycles;
  cbr_serial_regs cbr_serial_regs_i
  (
    .core_clk(core_clk),
    .rst(rst),
    .sclIn(scl),
    .sdaIn(sda),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .pin_enable_first_output(pins),
    .outputEnable(outputEnable)
  );
  cbr_host cbr_host_i
  (
    .core_clk(core_clk),
    .sdaOe(sdaOe),
    .sdaOut(sdaOut),
    .scl(scl),
    .sda(sda)
  );
  // ----
  // helpers
  // ----
  task automatic check(input string w, input logic [7:0] e,
                       input logic [7:0] g);
    totalChecks++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic completeRun();
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] d[$]);
    logic ok;
    cbr_host_i.start();
    cbr_host_i.xb(8'hD2, 1'b1, r, s);
    ok = ~s;
    cbr_host_i.xb(o, 1'b1, r, s);
    ok = ok & ~s;
    cbr_host_i.xb(8'(d.size()), 1'b1, r, s);
    ok = ok & ~s;
    foreach (d[i])
    begin
      cbr_host_i.xb(d[i], 1'b1, r, s);
      ok = ok & ~s;
    end
    cbr_host_i.stop();
    check("write acks", 8'h01, {7'h00, ok});
  endtask
  task automatic rd(input logic [7:0] o, input logic [7:0] e[$]);
    cbr_host_i.start();
    cbr_host_i.xb(8'hD2, 1'b1, r, s);
    cbr_host_i.xb(o, 1'b1, r, s);
    cbr_host_i.start();
    cbr_host_i.xb(8'hD3, 1'b1, r, s);
    check("read ack", 8'h00, {7'h00, s});
    cbr_host_i.xb(8'hFF, 1'b0, r, s);
    check("count", 8'(NUM_REGS), r);
    foreach (e[i])
    begin
      cbr_host_i.xb(8'hFF, i == e.size() - 1, r, s);
      check("read byte", e[i], r);
    end
    cbr_host_i.stop();
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    check("enables", 8'hFF, outputEnable);
    rd(8'h00, '{8'h0F, 0, 0, 0, 0, 0, {REV_RESET, MAKER_RESET}, 0});
  endtask
  task automatic t_enables();
    logic [7:0] d;
    d = 8'hF5;
    wr(8'h00, '{d});
    check("upper", {4'h0, d[0], d[1], d[2], d[3]},
          {4'h0, outputEnable[7:4]});
  endtask
  task automatic t_block();
    wr(8'h01, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'hC6, 8'h77, 8'h88});
    check("upper kept", 8'h0A, {4'h0, outputEnable[7:4]});
    rd(8'h00, '{8'hF5, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'hC6, 0});
  endtask
  task automatic t_bad_addr();
    logic [7:0] a[3];
    a = '{8'hD0, 8'hA4, 8'h52};
    foreach (a[i])
    begin
      cbr_host_i.start();
      cbr_host_i.xb(a[i], 1'b1, r, s);
      check("foreign ack", 8'h01, {7'h00, s});
      cbr_host_i.xb(8'h00, 1'b1, r, s);
      cbr_host_i.xb(8'h00, 1'b1, r, s);
      cbr_host_i.stop();
    end
    check("upper ignored", 8'h0A, {4'h0, outputEnable[7:4]});
  endtask
  task automatic t_pins();
    pins = 4'b0110;
    repeat (4) @(posedge core_clk);
    #1;
    check("pins", 8'hA6, outputEnable);
    pins = 4'b1001;
    repeat (4) @(posedge core_clk);
    #1;
    check("pins", 8'hA9, outputEnable);
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // transfers take a few thousand cycles; ten times that means a hang
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      completeRun();
    end
  end
  initial
  begin
    rst = 1'b1;
    pins = 4'hF;
    repeat (8) @(posedge core_clk);
    #1;
    rst = 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    t_reset();
    t_enables();
    t_block();
    t_bad_addr();
    t_pins();
    completeRun();
  end
endmodule
`default_nettype wire
